// >>> rtl/tx_probability_threshold_channel_access_rx_filter.sv
// Persistence channel access and receive frame acceptance for two radio ports
//
// The implementer's own choices: the APB slave port and the address map.
module tx_probability_threshold_channel_access_rx_filter (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Transmit side, per port
  input  wire logic [1:0]  txFrameQueued,
  input  wire logic [1:0]  carrierDetect,
  input  wire logic [1:0]  packetDetect,
  output logic      [1:0]  txKey,
  // Receive side: frame end report, port select, frame tag
  input  wire logic        rxFrameDone,
  input  wire logic        rxPort,
  input  wire logic        rxCrcOk,
  input  wire logic        rxOpenFlag,
  input  wire logic        rxCloseFlag,
  input  wire logic [6:0]  rxTag,
  output logic             rxFrameReady,
  // Upward delivery through FIFO, and registered log update with its port
  output logic      [7:0]  upData,
  output logic             upValid,
  input  wire logic        upReady,
  output logic             logUpdate,
  output logic             logPort
);

  // ==========================================================================
  // Pin synchronisers (three flops, change counts when last two agree)
  // ==========================================================================
  logic [1:0] carS1_r, carS2_r, carS3_r, carStable_r;
  logic [1:0] pktS1_r, pktS2_r, pktS3_r, pktStable_r;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      carS1_r     <= '0;
      carS2_r     <= '0;
      carS3_r     <= '0;
      carStable_r <= '0;
      pktS1_r     <= '0;
      pktS2_r     <= '0;
      pktS3_r     <= '0;
      pktStable_r <= '0;
    end
    else
    begin
      carS1_r     <= carrierDetect;
      carS2_r     <= carS1_r;
      carS3_r     <= carS2_r;
      carStable_r <= (carS2_r & carS3_r) | (carStable_r & (carS2_r | carS3_r));
      pktS1_r     <= packetDetect;
      pktS2_r     <= pktS1_r;
      pktS3_r     <= pktS2_r;
      pktStable_r <= (pktS2_r & pktS3_r) | (pktStable_r & (pktS2_r | pktS3_r));
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [1:0] passBad_r;
  logic [7:0] threshold_r [2];
  logic [7:0] slotSet_r   [2];
  logic [7:0] delaySet_r  [2];

  wire apbWrite = psel && penable && pwrite;
  wire apbRead  = psel && penable && !pwrite;
  wire hitCtrl  = (paddr == tx_probability_threshold_pkg::ADDR_CTRL);
  wire hitPer0  = (paddr == tx_probability_threshold_pkg::ADDR_PERSIST0);
  wire hitPer1  = (paddr == tx_probability_threshold_pkg::ADDR_PERSIST1);
  wire hitSlot0 = (paddr == tx_probability_threshold_pkg::ADDR_SLOT0);
  wire hitSlot1 = (paddr == tx_probability_threshold_pkg::ADDR_SLOT1);
  wire hitDw0   = (paddr == tx_probability_threshold_pkg::ADDR_DELAY0);
  wire hitDw1   = (paddr == tx_probability_threshold_pkg::ADDR_DELAY1);
  wire hitStat  = (paddr == tx_probability_threshold_pkg::ADDR_STATUS);
  wire hitAny   = hitCtrl | hitPer0 | hitPer1 | hitSlot0 | hitSlot1
                | hitDw0 | hitDw1 | hitStat;
  wire [31:0] statusWord;
  wire [31:0] readMux;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hitAny;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      passBad_r      <= '0;
      threshold_r[0] <= tx_probability_threshold_pkg::TX_PROBABILITY_THRESHOLD_RESET;
      threshold_r[1] <= tx_probability_threshold_pkg::TX_PROBABILITY_THRESHOLD_RESET;
      slotSet_r[0]   <= tx_probability_threshold_pkg::SLOT_RESET;
      slotSet_r[1]   <= tx_probability_threshold_pkg::SLOT_RESET;
      delaySet_r[0]  <= tx_probability_threshold_pkg::DELAY_RESET;
      delaySet_r[1]  <= tx_probability_threshold_pkg::DELAY_RESET;
    end
    else if (apbWrite)
    begin
      if (hitCtrl)
      begin
        passBad_r <= {pwdata[tx_probability_threshold_pkg::CTRL_PASS1_BIT],
                      pwdata[tx_probability_threshold_pkg::CTRL_PASS0_BIT]};
      end
      else if (hitPer0)
      begin
        threshold_r[0] <= pwdata[7:0];
      end
      else if (hitPer1)
      begin
        threshold_r[1] <= pwdata[7:0];
      end
      else if (hitSlot0)
      begin
        slotSet_r[0] <= pwdata[7:0];
      end
      else if (hitSlot1)
      begin
        slotSet_r[1] <= pwdata[7:0];
      end
      else if (hitDw0)
      begin
        delaySet_r[0] <= pwdata[7:0];
      end
      else if (hitDw1)
      begin
        delaySet_r[1] <= pwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  assign readMux = hitCtrl  ? {30'h0, passBad_r} :
                   hitPer0  ? {24'h0, threshold_r[0]} :
                   hitPer1  ? {24'h0, threshold_r[1]} :
                   hitSlot0 ? {24'h0, slotSet_r[0]} :
                   hitSlot1 ? {24'h0, slotSet_r[1]} :
                   hitDw0   ? {24'h0, delaySet_r[0]} :
                   hitDw1   ? {24'h0, delaySet_r[1]} :
                   hitStat  ? statusWord : 32'h0;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prdata <= 32'h0;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= readMux;
    end
  end

  // ==========================================================================
  // Random source and 10 ms tick
  // ==========================================================================
  logic [7:0]            lfsr_r;
  logic [tx_probability_threshold_pkg::TICK_CNT_W-1:0] tickCnt_r;
  logic                  tick_r;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      lfsr_r    <= tx_probability_threshold_pkg::LFSR_SEED;
      tickCnt_r <= '0;
      tick_r    <= 1'b0;
    end
    else
    begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      tick_r <= (tickCnt_r == tx_probability_threshold_pkg::TICK_CNT_W'(tx_probability_threshold_pkg::TICK_CYCLES - 1));
      if (tickCnt_r == tx_probability_threshold_pkg::TICK_CNT_W'(tx_probability_threshold_pkg::TICK_CYCLES - 1))
      begin
        tickCnt_r <= '0;
      end
      else
      begin
        tickCnt_r <= tickCnt_r + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Per-port access state machine
  // ==========================================================================
  typedef enum logic [1:0] {AC_IDLE, AC_DELAY, AC_SLOT, AC_SEND} access_t;
  access_t    acState_r [2];
  logic [7:0] acCount_r [2];
  logic [1:0] busyState;

  for (genvar p = 0; p < tx_probability_threshold_pkg::NUM_PORTS; p++)
  begin : g_port
    wire chanFree = !carStable_r[p] && !pktStable_r[p];
    wire slotDone = tick_r && (acCount_r[p] <= 8'h01);
    wire winDraw  = (lfsr_r <= threshold_r[p]);

    assign txKey[p]     = (acState_r[p] == AC_SEND);
    assign busyState[p] = (acState_r[p] != AC_IDLE);

    always_ff @(posedge clk_sys)
    begin
      if (reset)
      begin
        acState_r[p] <= AC_IDLE;
        acCount_r[p] <= '0;
      end
      else
      begin
        case (acState_r[p])
          AC_IDLE:
          begin
            if (txFrameQueued[p] && chanFree)
            begin
              acState_r[p] <= AC_DELAY;
              acCount_r[p] <= delaySet_r[p];
            end
          end
          AC_DELAY:
          begin
            if (!txFrameQueued[p] || !chanFree)
            begin
              acState_r[p] <= AC_IDLE;
            end
            else if (acCount_r[p] == 8'h00 || slotDone)
            begin
              acState_r[p] <= AC_SLOT;
              acCount_r[p] <= slotSet_r[p];
            end
            else if (tick_r)
            begin
              acCount_r[p] <= acCount_r[p] - 8'h01;
            end
          end
          AC_SLOT:
          begin
            if (!txFrameQueued[p] || !chanFree)
            begin
              acState_r[p] <= AC_IDLE;
            end
            else if (acCount_r[p] == 8'h00 || slotDone)
            begin
              if (winDraw)
              begin
                acState_r[p] <= AC_SEND;
              end
              else
              begin
                acCount_r[p] <= slotSet_r[p];
              end
            end
            else if (tick_r)
            begin
              acCount_r[p] <= acCount_r[p] - 8'h01;
            end
          end
          AC_SEND:
          begin
            if (!txFrameQueued[p])
            begin
              acState_r[p] <= AC_IDLE;
            end
          end
          default:
          begin
            acState_r[p] <= AC_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Receive acceptance
  // ==========================================================================
  wire       portPass = passBad_r[rxPort];
  wire       acceptGood = rxCrcOk;
  wire       acceptBad  = portPass && !rxCrcOk && rxOpenFlag && rxCloseFlag;
  wire       accept   = rxFrameDone && (acceptGood || acceptBad);
  wire       fifoInReady;
  wire [7:0] fifoIn   = {rxPort, rxTag};

  assign rxFrameReady = fifoInReady;
  assign statusWord   = {28'h0, busyState, fifoInReady, upValid};

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      logUpdate <= 1'b0;
      logPort   <= 1'b0;
    end
    else
    begin
      logUpdate <= accept && fifoInReady && !portPass;
      logPort   <= rxPort;
    end
  end

  frame_fifo #(
    .WIDTH (tx_probability_threshold_pkg::RX_WIDTH),
    .DEPTH (tx_probability_threshold_pkg::RX_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .inData   (fifoIn),
    .inValid  (accept),
    .inReady  (fifoInReady),
    .outData  (upData),
    .outValid (upValid),
    .outReady (upReady)
  );

endmodule // tx_probability_threshold_channel_access_rx_filter

// >>> rtl/tx_probability_threshold_pkg.sv
// Constants for the channel access and receive acceptance block
package tx_probability_threshold_pkg;

  // ==========================================================================
  // Register map (byte addresses, one word per port for each per-port setting but the pass bits, which share CTRL)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_PERSIST0 = 8'h04;
  localparam logic [7:0] ADDR_PERSIST1 = 8'h08;
  localparam logic [7:0] ADDR_SLOT0    = 8'h0C;
  localparam logic [7:0] ADDR_SLOT1    = 8'h10;
  localparam logic [7:0] ADDR_DELAY0   = 8'h14;
  localparam logic [7:0] ADDR_DELAY1   = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1C;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int CTRL_PASS0_BIT = 0;
  localparam int CTRL_PASS1_BIT = 1;
  localparam logic [7:0] TX_PROBABILITY_THRESHOLD_RESET = 8'h3F;
  localparam logic [7:0] SLOT_RESET    = 8'h0A;
  localparam logic [7:0] DELAY_RESET   = 8'h00;
  localparam logic [7:0] LFSR_SEED     = 8'hA5;
  localparam int NUM_PORTS = 2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ        = 25000000;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_CNT_W    = 18;

  // ==========================================================================
  // Receive frame FIFO
  // ==========================================================================
  localparam int RX_WIDTH = 8;
  localparam int RX_DEPTH = 16;

endpackage

// >>> rtl/frame_fifo.sv
// Synchronous FIFO with valid and ready on both sides
module frame_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  wire              doWrite;
  wire              doRead;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;
  assign outData  = mem[rdPtr_r];

  always_ff @(posedge clk_sys)
  begin
    if (doWrite)
    begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (doWrite)
      begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doRead)
      begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= count_r + {{AW{1'b0}}, doWrite} - {{AW{1'b0}}, doRead};
    end
  end
endmodule // frame_fifo

// >>> bench/radio_channel_model.sv
// Radio channel model driving carrier and packet detect toward the block
module radio_channel_model (
  input  wire logic       clk_sys,
  input  wire logic [1:0] chanBusy,
  output logic      [1:0] carrierDetect,
  output logic      [1:0] packetDetect
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Detect lines
  // ==========================================================================
  // Carrier follows the commanded channel state
  assign carrierDetect = chanBusy;
  // Packet detect trails the carrier by one decode cycle
  always_ff @(posedge clk_sys)
    packetDetect <= carrierDetect;
endmodule // radio_channel_model

// >>> bench/tx_probability_threshold_channel_access_rx_filter_sva.sv
// Assertion checker for channel access and receive acceptance
module tx_probability_threshold_channel_access_rx_filter_sva (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [1:0] txFrameQueued,
  input wire logic [1:0] carrierDetect,
  input wire logic [1:0] packetDetect,
  input wire logic [1:0] txKey,
  input wire logic       rxFrameDone,
  input wire logic       rxPort,
  input wire logic       rxCrcOk,
  input wire logic       rxOpenFlag,
  input wire logic       rxCloseFlag,
  input wire logic       rxFrameReady,
  input wire logic [7:0] upData,
  input wire logic       upValid,
  input wire logic       upReady,
  input wire logic       logUpdate,
  input wire logic       logPort
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================================
  // Receive acceptance
  // ==========================================================================
  rx_good_a: assert property (rxFrameDone && rxFrameReady && rxCrcOk |=> upValid)
    else $error("good frame not delivered");
  bad_flag_a: assert property (rxFrameDone && !rxCrcOk && !(rxOpenFlag && rxCloseFlag)
    && !upValid |=> !upValid) else $error("unframed bad frame delivered");
  rx_nolog_a: assert property (rxFrameDone && !rxCrcOk |=> !logUpdate)
    else $error("log updated for bad frame");
  log_cause_a: assert property (logUpdate |-> $past(rxFrameDone && rxFrameReady))
    else $error("log update without report");
  log_port_a: assert property (logUpdate |-> logPort == $past(rxPort))
    else $error("log port wrong");
  up_hold_a: assert property (upValid && !upReady |=> upValid && $stable(upData))
    else $error("upward data not held");
  // ==========================================================================
  // Channel access and APB answer
  // ==========================================================================
  key_busy_a: assert property ((carrierDetect[0] || packetDetect[0]) [*6]
    |-> !$rose(txKey[0])) else $error("keyed on busy channel");
  key_queue_a: assert property ($rose(txKey[0]) |-> txFrameQueued[0])
    else $error("keyed without frame");
  key_hold_a: assert property (txKey[0] && txFrameQueued[0] |=> txKey[0])
    else $error("key dropped early");
  apb_err_a: assert property (psel && penable |-> pready
    && pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0)) else $error("apb answer wrong");
endmodule // tx_probability_threshold_channel_access_rx_filter_sva

bind tx_probability_threshold_channel_access_rx_filter tx_probability_threshold_channel_access_rx_filter_sva chk (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .txFrameQueued(txFrameQueued),
  .carrierDetect(carrierDetect), .packetDetect(packetDetect), .txKey(txKey),
  .rxFrameDone(rxFrameDone), .rxPort(rxPort), .rxCrcOk(rxCrcOk), .rxOpenFlag(rxOpenFlag),
  .rxCloseFlag(rxCloseFlag), .rxFrameReady(rxFrameReady), .upData(upData),
  .upValid(upValid), .upReady(upReady), .logUpdate(logUpdate), .logPort(logPort));

// >>> bench/tx_probability_threshold_channel_access_rx_filter_tb.sv
// Testbench for channel access and receive acceptance
module tx_probability_threshold_channel_access_rx_filter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, upData;
  logic [31:0] pwdata, prdata;
  logic [1:0]  txFrameQueued, chanBusy, carrierDetect, packetDetect, txKey;
  logic        rxFrameDone, rxPort, rxCrcOk, rxOpenFlag, rxCloseFlag, rxFrameReady;
  logic [6:0]  rxTag;
  logic        upValid, upReady, logUpdate, logPort;
  int          n_errors, total_checks, cyc;
  tx_probability_threshold_channel_access_rx_filter DUT (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txFrameQueued(txFrameQueued),
    .carrierDetect(carrierDetect), .packetDetect(packetDetect), .txKey(txKey),
    .rxFrameDone(rxFrameDone), .rxPort(rxPort), .rxCrcOk(rxCrcOk), .rxOpenFlag(rxOpenFlag),
    .rxCloseFlag(rxCloseFlag), .rxTag(rxTag), .rxFrameReady(rxFrameReady), .upData(upData),
    .upValid(upValid), .upReady(upReady), .logUpdate(logUpdate), .logPort(logPort));
  radio_channel_model chan (.clk_sys(clk_sys), .chanBusy(chanBusy),
    .carrierDetect(carrierDetect), .packetDetect(packetDetect));
  // ==========================================================================
  // Clock, timeout and shared tasks
  // ==========================================================================
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      $display("[ERR] %0t run timed out", $time);
      summarize();
    end
  end
  task automatic summarize;
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0, rd, e);
    check(rd, exp, "register read");
    check(e, expErr, "register error");
  endtask
  task automatic rx(input int p, input logic crc, op, cl, input logic [6:0] tag);
    @(posedge clk_sys);
    rxPort <= p[0];
    rxCrcOk <= crc;
    rxOpenFlag <= op;
    rxCloseFlag <= cl;
    rxTag <= tag;
    rxFrameDone <= 1'b1;
    @(posedge clk_sys);
    rxFrameDone <= 1'b0;
    #1;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs;
    rreg(tx_probability_threshold_pkg::ADDR_CTRL, 32'h0, 1'b0);
    rreg(tx_probability_threshold_pkg::ADDR_PERSIST0, 32'h3F, 1'b0);
    rreg(tx_probability_threshold_pkg::ADDR_PERSIST1, 32'h3F, 1'b0);
    rreg(tx_probability_threshold_pkg::ADDR_SLOT1, 32'h0A, 1'b0);
    rreg(tx_probability_threshold_pkg::ADDR_DELAY0, 32'h0, 1'b0);
    rreg(tx_probability_threshold_pkg::ADDR_STATUS, 32'h2, 1'b0);
    wreg(tx_probability_threshold_pkg::ADDR_PERSIST1, 32'hFFFFFF5A);
    rreg(tx_probability_threshold_pkg::ADDR_PERSIST1, 32'h5A, 1'b0);
    rreg(8'h20, 32'h0, 1'b1);
  endtask
  task automatic t_tx;
    int n;
    for (int p = 0; p < 2; p++)
    begin
      wreg(tx_probability_threshold_pkg::ADDR_SLOT0 + 8'(4 * p), 32'h0);
      wreg(tx_probability_threshold_pkg::ADDR_DELAY0 + 8'(4 * p), 32'h0);
      wreg(tx_probability_threshold_pkg::ADDR_PERSIST0 + 8'(4 * p), 32'hFF);
      chanBusy[p] <= 1'b1;
      repeat (5) @(posedge clk_sys);
      txFrameQueued[p] <= 1'b1;
      repeat (40) @(posedge clk_sys);
      #1 check(txKey[p], 1'b0, "keyed while busy");
      @(posedge clk_sys);
      chanBusy[p] <= 1'b0;
      for (n = 0; n < 100 && txKey[p] !== 1'b1; n++) @(posedge clk_sys) #1;
      repeat (10) @(posedge clk_sys);
      #1 check(txKey[p], 1'b1, "no key on free channel");
      @(posedge clk_sys);
      txFrameQueued[p] <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 check(txKey[p], 1'b0, "key not released");
    end
    wreg(tx_probability_threshold_pkg::ADDR_PERSIST0, 32'h0);
    txFrameQueued[0] <= 1'b1;
    n = 0;
    repeat (300)
    begin
      @(posedge clk_sys) #1;
      n += int'(txKey[0] === 1'b1);
    end
    check(n, 0, "keyed above threshold");
    wreg(tx_probability_threshold_pkg::ADDR_PERSIST0, 32'h80);
    for (n = 0; n < 300 && txKey[0] !== 1'b1; n++) @(posedge clk_sys) #1;
    check(txKey[0], 1'b1, "no key after fresh draws");
    @(posedge clk_sys);
    txFrameQueued[0] <= 1'b0;
    wreg(tx_probability_threshold_pkg::ADDR_PERSIST0, 32'hFF);
    wreg(tx_probability_threshold_pkg::ADDR_DELAY0, 32'h1);
    txFrameQueued[0] <= 1'b1;
    n = 0;
    repeat (500)
    begin
      @(posedge clk_sys) #1;
      n += int'(txKey[0] === 1'b1);
    end
    check(n, 0, "keyed before fixed delay");
    @(posedge clk_sys);
    txFrameQueued[0] <= 1'b0;
  endtask
  task automatic t_rx;
    logic [5:0] pass, crc, op, cl, acc, lg;
    {pass, crc, op, cl} = {6'h3C, 6'h21, 6'h2F, 6'h37};
    {acc, lg} = {6'h25, 6'h01};
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 6; m++)
      begin
        wreg(tx_probability_threshold_pkg::ADDR_CTRL, pass[m] ? 32'h3 : 32'h0);
        rx(p, crc[m], op[m], cl[m], 7'(m + 8 * p));
        check(upValid, acc[m], "acceptance");
        if (acc[m])
          check(upData, {p[0], 7'(m + 8 * p)}, "upward data");
        check(logUpdate, lg[m], "log update");
        if (lg[m])
          check(logPort, p[0], "log port");
      end
  endtask
  task automatic t_fifo;
    wreg(tx_probability_threshold_pkg::ADDR_CTRL, 32'h0);
    upReady <= 1'b0;
    for (int i = 0; i < 16; i++)
      rx(0, 1'b1, 1'b1, 1'b1, 7'(i));
    check(rxFrameReady, 1'b0, "fifo not full");
    rx(0, 1'b1, 1'b1, 1'b1, 7'h7F);
    @(posedge clk_sys);
    upReady <= 1'b1;
    #1;
    for (int i = 0; i < 16; i++)
    begin
      check(upValid, 1'b1, "fifo drained early");
      check(upData, 8'(i), "fifo order");
      @(posedge clk_sys) #1;
    end
    check(upValid, 1'b0, "frame taken while full");
    check(rxFrameReady, 1'b1, "fifo not ready");
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {txFrameQueued, chanBusy} = '0;
    {rxFrameDone, rxPort, rxCrcOk, rxOpenFlag, rxCloseFlag, rxTag} = '0;
    upReady = 1'b1;
    reset = 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_tx();
    t_rx();
    t_fifo();
    summarize();
  end
endmodule // tx_probability_threshold_channel_access_rx_filter_tb
